// >>> design/ecprh_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module ecprh_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             core_clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [AW:0]      level_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  reg [WIDTH-1:0] out_data_reg;
  reg             out_valid_reg;

  wire [AW:0] count    = wr_ptr_reg - rd_ptr_reg;
  wire        full     = (count == DEPTH[AW:0]);
  wire        empty    = (count == {(AW+1){1'b0}});
  wire        push     = in_valid_i && !full;
  wire        load_out = !empty && (!out_valid_reg || out_ready_i);

  always @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // Output stage is a register, so the head word leaves the array on load
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg    <= {(AW+1){1'b0}};
      rd_ptr_reg    <= {(AW+1){1'b0}};
      out_data_reg  <= {WIDTH{1'b0}};
      out_valid_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
      end
      if (load_out) begin
        out_data_reg  <= mem[rd_ptr_reg[AW-1:0]];
        out_valid_reg <= 1'b1;
        rd_ptr_reg    <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
      end else if (out_ready_i) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  assign in_ready_o  = !full;
  assign out_data_o  = out_data_reg;
  assign out_valid_o = out_valid_reg;
  assign level_o     = count;

endmodule

`default_nettype wire

// >>> design/ecprh_filter.v
// Stability filter for one peripheral status input
`timescale 1ns/10ps
`default_nettype none

module ecprh_filter #(
  parameter                CNT_W = 4,
  parameter [CNT_W-1:0]    STABLE_CYC = 4'h8,
  parameter                INIT = 1'b1
) (
  input  wire              core_clk_i,
  input  wire              rst_n_i,
  input  wire              raw_i,
  output wire              level_o,
  output wire              change_o
);

  reg             level_reg;
  reg             cand_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg             change_reg;

  // A new level is accepted only after it holds for STABLE_CYC clocks
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg  <= INIT;
      cand_reg   <= INIT;
      cnt_reg    <= {CNT_W{1'b0}};
      change_reg <= 1'b0;
    end else begin
      change_reg <= 1'b0;
      if (raw_i != cand_reg) begin
        cand_reg <= raw_i;
        cnt_reg  <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (cand_reg != level_reg) begin
        if (cnt_reg >= STABLE_CYC - {{(CNT_W-1){1'b0}}, 1'b1}) begin
          level_reg  <= cand_reg;
          change_reg <= 1'b1;
          cnt_reg    <= {CNT_W{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end else begin
        cnt_reg <= {CNT_W{1'b0}};
      end
    end
  end

  assign level_o  = level_reg;
  assign change_o = change_reg;

endmodule

`default_nettype wire

// >>> design/ecprh_regs.vh
// Constants for the ECP reverse-channel host handshake block
`ifndef ECPRH_REGS_VH
`define ECPRH_REGS_VH

`define ECPRH_CLK_PERIOD_NS   10
`define ECPRH_FILT_MIN_NS     75
`define ECPRH_FILT_MAX_NS     130
// Least time rounds up to whole cycles
`define ECPRH_FILT_CYC        ((`ECPRH_FILT_MIN_NS + `ECPRH_CLK_PERIOD_NS - 1) / `ECPRH_CLK_PERIOD_NS)
`define ECPRH_FILT_MAX_CYC    (`ECPRH_FILT_MAX_NS / `ECPRH_CLK_PERIOD_NS)
`define ECPRH_FILT_CNT_W      4

`define ECPRH_DATA_W          8
`define ECPRH_FIFO_DEPTH      32
`define ECPRH_FIFO_AW         5
`define ECPRH_CNT_W           16

`define ECPRH_ST_W            2
`define ECPRH_ST_OFF          2'h0
`define ECPRH_ST_WAIT         2'h1
`define ECPRH_ST_ACK          2'h2

`define ECPRH_PIN_IDLE        1'h1
`define ECPRH_HOSTACK_FWD     1'h1

`endif

// >>> design/ecprh_reverse.v
// Host end of the ECP reverse data phase with pin drivers and input filters
`timescale 1ns/10ps
`default_nettype none
`include "ecprh_regs.vh"

module ecprh_reverse (
  input  wire                      core_clk_i,
  input  wire                      rst_n_i,
  // Mode control and forward data from the port logic
  input  wire                      ecp_mode_i,
  input  wire                      reverse_i,
  input  wire                      stall_i,
  input  wire [`ECPRH_DATA_W-1:0]  fwd_data_i,
  // Cable side
  input  wire [`ECPRH_DATA_W-1:0]  pdata_i,
  output wire [`ECPRH_DATA_W-1:0]  pdata_o,
  output wire                      pdata_oe_o,
  input  wire                      periph_clk_i,
  input  wire                      busy_i,
  output wire                      host_ack_o,
  output wire                      host_ack_oe_o,
  output wire                      host_clk_o,
  output wire                      host_clk_oe_o,
  // Filtered status
  output wire                      busy_o,
  output wire                      busy_change_o,
  output wire                      periph_clk_o,
  // Received byte stream
  output wire [`ECPRH_DATA_W-1:0]  rx_data_o,
  output wire                      rx_valid_o,
  input  wire                      rx_ready_i,
  output wire [`ECPRH_FIFO_AW:0]   rx_level_o,
  // Status
  output wire                      reverse_active_o,
  output wire                      ecp_drivers_o,
  output wire                      stalled_o,
  output wire [`ECPRH_CNT_W-1:0]   rx_count_o
);

  localparam [`ECPRH_ST_W-1:0] ST_OFF  = `ECPRH_ST_OFF;
  localparam [`ECPRH_ST_W-1:0] ST_WAIT = `ECPRH_ST_WAIT;
  localparam [`ECPRH_ST_W-1:0] ST_ACK  = `ECPRH_ST_ACK;
  // Filter count is worked out in integer arithmetic, then cut to the counter width
  localparam integer                 FILT_CYC_N = `ECPRH_FILT_CYC;
  localparam [`ECPRH_FILT_CNT_W-1:0] FILT_CYC = FILT_CYC_N[`ECPRH_FILT_CNT_W-1:0];

  reg [`ECPRH_ST_W-1:0]    state_reg;
  reg [`ECPRH_ST_W-1:0]    state_next;
  reg                      host_ack_reg;
  reg                      host_ack_next;
  reg [`ECPRH_DATA_W-1:0]  cap_data_reg;
  reg [`ECPRH_DATA_W-1:0]  cap_data_next;
  reg                      push_reg;
  reg                      push_next;
  reg                      drv_ecp_reg;
  reg                      drv_ecp_next;
  reg [`ECPRH_DATA_W-1:0]  pdata_reg;
  reg                      pdata_oe_reg;
  reg                      host_ack_oe_reg;
  reg                      host_clk_oe_reg;
  reg                      stalled_reg;
  reg [`ECPRH_CNT_W-1:0]   rx_count_reg;

  wire periph_clk_f;
  wire periph_clk_chg;
  wire busy_f;
  wire busy_chg;
  wire fifo_in_ready;

  // Open-collector drives only a low; push-pull drives both levels
  function drive_enable;
    input ecp_drv;
    input level;
    begin
      drive_enable = ecp_drv | ~level;
    end
  endfunction

  ecprh_filter #(
    .CNT_W      (`ECPRH_FILT_CNT_W),
    .STABLE_CYC (FILT_CYC),
    .INIT       (1'b1)
  ) u_filt_periph_clk (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .raw_i      (periph_clk_i),
    .level_o    (periph_clk_f),
    .change_o   (periph_clk_chg)
  );

  ecprh_filter #(
    .CNT_W      (`ECPRH_FILT_CNT_W),
    .STABLE_CYC (FILT_CYC),
    .INIT       (1'b0)
  ) u_filt_busy (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .raw_i      (busy_i),
    .level_o    (busy_f),
    .change_o   (busy_chg)
  );

  ecprh_fifo #(
    .WIDTH (`ECPRH_DATA_W),
    .DEPTH (`ECPRH_FIFO_DEPTH),
    .AW    (`ECPRH_FIFO_AW)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (cap_data_reg),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (rx_data_o),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .level_o     (rx_level_o)
  );

  // No new byte is taken while a push is pending or while the FIFO is full
  wire fifo_room = fifo_in_ready && !push_reg;
  wire hold_off  = stall_i || !fifo_room;

  // Reverse handshake sequencer
  always @* begin
    state_next    = state_reg;
    host_ack_next = host_ack_reg;
    cap_data_next = cap_data_reg;
    push_next     = 1'b0;
    case (state_reg)
      ST_OFF: begin
        host_ack_next = `ECPRH_HOSTACK_FWD;
        if (reverse_i) begin
          state_next    = ST_WAIT;
          host_ack_next = 1'b0;
        end
      end
      ST_WAIT: begin
        host_ack_next = 1'b0;
        if (!reverse_i) begin
          state_next    = ST_OFF;
          host_ack_next = `ECPRH_HOSTACK_FWD;
        end else if (!periph_clk_f && !hold_off) begin
          // Byte is taken while PeriphClk is qualified low
          cap_data_next = pdata_i;
          push_next     = 1'b1;
          state_next    = ST_ACK;
          host_ack_next = 1'b1;
        end
        // Holding here keeps HostAck low and stalls the peripheral
      end
      ST_ACK: begin
        host_ack_next = 1'b1;
        if (periph_clk_f) begin
          state_next    = ST_WAIT;
          host_ack_next = 1'b0;
        end
      end
      default: begin
        state_next    = ST_OFF;
        host_ack_next = `ECPRH_HOSTACK_FWD;
      end
    endcase
  end

  // Driver type changes in any state but ST_ACK, including the edge that enters ST_ACK and raises HostAck
  always @* begin
    drv_ecp_next = drv_ecp_reg;
    if (state_reg != ST_ACK && ecp_mode_i != drv_ecp_reg) begin
      drv_ecp_next = ecp_mode_i;
    end
  end

  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_OFF;
      host_ack_reg <= `ECPRH_HOSTACK_FWD;
      cap_data_reg <= {`ECPRH_DATA_W{1'b0}};
      push_reg     <= 1'b0;
      drv_ecp_reg  <= 1'b0;
      stalled_reg  <= 1'b0;
      rx_count_reg <= {`ECPRH_CNT_W{1'b0}};
    end else begin
      state_reg    <= state_next;
      host_ack_reg <= host_ack_next;
      cap_data_reg <= cap_data_next;
      push_reg     <= push_next;
      drv_ecp_reg  <= drv_ecp_next;
      stalled_reg  <= (state_reg == ST_WAIT) && !periph_clk_f && hold_off;
      if (push_reg) begin
        rx_count_reg <= rx_count_reg + {{(`ECPRH_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Pin stage: every enable comes from a flop fed from the next values, so a driver-type
  // change lands in the same edge as the level change that goes with it
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pdata_reg       <= {`ECPRH_DATA_W{1'b0}};
      pdata_oe_reg    <= 1'b0;
      host_ack_oe_reg <= 1'b0;
      host_clk_oe_reg <= 1'b0;
    end else begin
      pdata_reg       <= fwd_data_i;
      // Data lines are released while the peripheral drives them
      pdata_oe_reg    <= (state_next == ST_OFF) && !reverse_i;
      host_ack_oe_reg <= drive_enable(drv_ecp_next, host_ack_next);
      host_clk_oe_reg <= drive_enable(drv_ecp_next, `ECPRH_PIN_IDLE);
    end
  end

  assign pdata_o          = pdata_reg;
  assign pdata_oe_o       = pdata_oe_reg;
  assign host_ack_o       = host_ack_reg;
  assign host_ack_oe_o    = host_ack_oe_reg;
  assign host_clk_o       = `ECPRH_PIN_IDLE;
  assign host_clk_oe_o    = host_clk_oe_reg;
  assign busy_o           = busy_f;
  assign busy_change_o    = busy_chg;
  assign periph_clk_o     = periph_clk_f;
  assign reverse_active_o = (state_reg != ST_OFF);
  assign ecp_drivers_o    = drv_ecp_reg;
  assign stalled_o        = stalled_reg;
  assign rx_count_o       = rx_count_reg;

  // PeriphClk change pulse is only observed through the filtered level
  wire unused_ok = periph_clk_chg;

endmodule

`default_nettype wire

// >>> verif/ecp_reverse_handshake_tb.sv
// Testbench for the ECP reverse host handshake
`timescale 1ns/10ps
`default_nettype none
module ecp_reverse_handshake_tb;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       ecp_mode_i = 1'b0;
  logic       reverse_i = 1'b0;
  logic       stall_i = 1'b0;
  logic       busy_i = 1'b0;
  logic       rx_ready_i = 1'b0;
  logic       en = 1'b0;
  logic [3:0] setup = 4'h1;
  logic [7:0] fwd_data_i = 8'h00;
  logic [7:0] exp_k = 8'h00;
  wire        pclk, host_ack_o, host_ack_oe_o, host_clk_oe_o, pdata_oe_o;
  wire        busy_o, rx_valid_o, ecp_drivers_o, stalled_o;
  wire        host_clk_o, busy_change_o, reverse_active_o;
  wire [15:0] rx_count_o;
  int         n_busy_chg = 0;
  wire  [7:0] pd, pdata_o, rx_data_o;
  wire  [5:0] rx_level_o;
  int         bad_count = 0;
  int         n_tests = 0;
  always #5 core_clk_i = ~core_clk_i;
  // Change pulses stand one full cycle, so each is seen at exactly one falling edge
  always @(negedge core_clk_i) if (busy_change_o === 1'b1) n_busy_chg++;
  ecprh_reverse dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ecp_mode_i(ecp_mode_i), .reverse_i(reverse_i),
    .stall_i(stall_i), .fwd_data_i(fwd_data_i), .pdata_i(pdata_oe_o ? pdata_o : pd), .pdata_o(pdata_o),
    .pdata_oe_o(pdata_oe_o), .periph_clk_i(pclk), .busy_i(busy_i), .host_ack_o(host_ack_o),
    .host_ack_oe_o(host_ack_oe_o), .host_clk_o(host_clk_o), .host_clk_oe_o(host_clk_oe_o), .busy_o(busy_o),
    .busy_change_o(busy_change_o), .periph_clk_o(), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .rx_level_o(rx_level_o), .reverse_active_o(reverse_active_o),
    .ecp_drivers_o(ecp_drivers_o), .stalled_o(stalled_o), .rx_count_o(rx_count_o));
  ecprh_periph periph_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .en_i(en),
    .host_ack_i(host_ack_oe_o ? host_ack_o : 1'b1), .setup_i(setup), .pclk_o(pclk), .data_o(pd));
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic get_byte;
    int i;
    i = 0;
    while (rx_valid_o !== 1'b1 && i < 800) begin
      @(negedge core_clk_i);
      i++;
    end
    if (i == 800) begin
      bad_count++;
      tally_and_finish;
    end else begin
      chk(rx_data_o, 8'hA0 + exp_k);
      rx_ready_i = 1'b1;
      @(negedge core_clk_i);
      rx_ready_i = 1'b0;
      exp_k = exp_k + 8'h01;
    end
  endtask
  task automatic t_modes;
    repeat (2) @(negedge core_clk_i);
    chk({host_ack_o, host_ack_oe_o, host_clk_oe_o}, 3'h4);
    chk({pdata_oe_o, pdata_o}, 9'h15A);
    chk({reverse_active_o, host_clk_o}, 2'h1);
    ecp_mode_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk({ecp_drivers_o, host_ack_oe_o, host_clk_oe_o}, 3'h7);
    ecp_mode_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk({ecp_drivers_o, host_ack_oe_o, host_clk_oe_o}, 3'h0);
    ecp_mode_i = 1'b1;
  endtask
  task automatic t_stream;
    reverse_i = 1'b1;
    en = 1'b1;
    repeat (4) get_byte;
    chk({reverse_active_o, pdata_oe_o}, 2'h2);
    setup = 4'h6;
    repeat (2) get_byte;
    en = 1'b0;
  endtask
  task automatic t_stall;
    stall_i = 1'b1;
    en = 1'b1;
    repeat (60) @(negedge core_clk_i);
    chk({host_ack_o, stalled_o}, 2'h1);
    stall_i = 1'b0;
    en = 1'b0;
    get_byte;
  endtask
  task automatic t_fill;
    int i;
    i = 0;
    setup = 4'h1;
    en = 1'b1;
    while (stalled_o !== 1'b1 && i < 3000) begin
      @(negedge core_clk_i);
      i++;
    end
    if (i == 3000) begin
      bad_count++;
      tally_and_finish;
    end else begin
      chk({stalled_o, host_ack_o, rx_level_o}, {2'h2, 6'h20});
      en = 1'b0;
      repeat (34) get_byte;
      repeat (40) @(negedge core_clk_i);
      chk({rx_valid_o, rx_level_o}, 7'h00);
      chk(rx_count_o, 16'h0029);
    end
  endtask
  task automatic t_busy;
    busy_i = 1'b1;
    repeat (7) @(negedge core_clk_i);
    busy_i = 1'b0;
    repeat (20) @(negedge core_clk_i);
    chk(busy_o, 1'b0);
    busy_i = 1'b1;
    repeat (14) @(negedge core_clk_i);
    chk(busy_o, 1'b1);
    busy_i = 1'b0;
    repeat (14) @(negedge core_clk_i);
    chk(busy_o, 1'b0);
    chk(n_busy_chg[15:0], 16'h0002);
  endtask
  initial begin
    repeat (8) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    fwd_data_i = 8'h5A;
    t_modes;
    t_stream;
    t_stall;
    t_fill;
    t_busy;
    tally_and_finish;
  end
  initial begin
    repeat (60000) @(posedge core_clk_i);
    bad_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// >>> verif/ecprh_periph.sv
// Behavioural ECP peripheral sending a byte stream in the reverse phase
`timescale 1ns/10ps
`default_nettype none
module ecprh_periph (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       en_i,
  input  wire logic       host_ack_i,
  input  wire logic [3:0] setup_i,
  output var  logic       pclk_o,
  output var  logic [7:0] data_o
);
  logic [7:0] k;
  initial begin
    pclk_o = 1'b1;
    data_o = 8'h00;
    k = 8'h00;
    forever begin
      @(negedge core_clk_i);
      // Lines toggle while nothing is offered
      data_o = ~data_o;
      if (rst_n_i && en_i && !host_ack_i) begin
        data_o = 8'hA0 + k;
        repeat (setup_i) @(negedge core_clk_i);
        pclk_o = 1'b0;
        while (!host_ack_i) @(negedge core_clk_i);
        pclk_o = 1'b1;
        k = k + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/ecprh_reverse_assertions.sv
// Checker for the ECP reverse host handshake
`timescale 1ns/10ps
`default_nettype none
module ecprh_reverse_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        reverse_i,
  input wire logic        stall_i,
  input wire logic        periph_clk_i,
  input wire logic        busy_i,
  input wire logic        host_ack_o,
  input wire logic        host_ack_oe_o,
  input wire logic        host_clk_oe_o,
  input wire logic        busy_o,
  input wire logic        periph_clk_o,
  input wire logic        reverse_active_o,
  input wire logic        ecp_drivers_o,
  input wire logic [15:0] rx_count_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_ENTRY: assert property ($rose(reverse_active_o) |-> ##[0:2] !host_ack_o)
    else $error("HostAck high on entry");
  AST_ACK_RISE: assert property (reverse_active_o && $rose(host_ack_o) |-> !$past(periph_clk_o) && !$past(stall_i))
    else $error("HostAck rose without offer");
  AST_ACK_HOLD: assert property (reverse_active_o && host_ack_o && !periph_clk_o |=> host_ack_o)
    else $error("HostAck dropped early");
  AST_ACK_FALL: assert property (reverse_active_o && $past(reverse_active_o) && $fell(host_ack_o) |-> $past(periph_clk_o))
    else $error("HostAck fell with PeriphClk low");
  AST_STALL: assert property (reverse_active_o && reverse_i && stall_i && !host_ack_o |=> !host_ack_o)
    else $error("HostAck rose while stalled");
  AST_PUSHPULL: assert property (ecp_drivers_o |-> host_clk_oe_o && host_ack_oe_o)
    else $error("Driver off in ECP mode");
  AST_OPEN_DRAIN: assert property (!ecp_drivers_o |-> !host_clk_oe_o && !(host_ack_oe_o && host_ack_o))
    else $error("Driven high in compatible mode");
  AST_PCLK_FILT: assert property ($changed(periph_clk_o) |-> $past(periph_clk_i) == periph_clk_o &&
    $past(periph_clk_i, 8) == periph_clk_o)
    else $error("PeriphClk passed unfiltered");
  AST_BUSY_FILT: assert property ($changed(busy_o) |-> $past(busy_i) == busy_o && $past(busy_i, 8) == busy_o)
    else $error("Busy passed unfiltered");
  AST_COUNT: assert property (reverse_active_o && $rose(host_ack_o) |=> rx_count_o == $past(rx_count_o) + 16'h0001)
    else $error("Byte not taken");
endmodule
bind ecprh_reverse ecprh_reverse_chk chk_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reverse_i(reverse_i),
  .stall_i(stall_i), .periph_clk_i(periph_clk_i), .busy_i(busy_i), .host_ack_o(host_ack_o),
  .host_ack_oe_o(host_ack_oe_o), .host_clk_oe_o(host_clk_oe_o), .busy_o(busy_o), .periph_clk_o(periph_clk_o),
  .reverse_active_o(reverse_active_o), .ecp_drivers_o(ecp_drivers_o), .rx_count_o(rx_count_o));
`default_nettype wire
